/* File: rtc_oscillator_power_mode_control_tb.sv */
// testbench for the real time clock start-up and supply control
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
  end \
end
module rtc_oscillator_power_mode_control_tb;
  logic       i_clock, i_rst, cs_n, rd_n, wr_n, oe, osc, stby, pf_n;
  logic       bb, armed, irq, ok;
  logic [4:0] addr;
  logic [7:0] wdat, rdat, d;
  logic [1:0] xs;
  logic [2:0] k;
  int         error_cnt, compares, cyc, n;

  // host model on the bus
  rtcp_host h (.i_clock(i_clock), .i_data(rdat), .i_data_oe(oe),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_addr(addr),
    .o_data(wdat));

  // short tick so calendar rollover fits the run
  rtcp_core #(.TICK_CYCLES(4)) i_dut (.i_clock(i_clock), .i_rst(i_rst),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_addr(addr),
    .i_data(wdat), .o_data(rdat), .o_data_oe(oe), .i_osc_running(osc),
    .i_backup_above_main(stby), .i_power_fail_input_n(pf_n),
    .o_crystal_select(xs), .o_battery_backed(bb),
    .o_power_fail_armed(armed), .o_interrupt(irq));

  // 50 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // counts and verdict
  task automatic finish_test;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      finish_test;
    end
  end

  // read and compare masked bits, answer required
  task automatic rc(input logic [4:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    h.rd(a, d, ok);
    `CHK({ok, d & m}, {1'b1, e})
  endtask

  // let registered outputs follow a write
  task automatic settle;
    repeat (2) @(negedge i_clock);
  endtask

  initial begin
    i_rst = 1'b1;
    osc = 1'b0;
    stby = 1'b0;
    pf_n = 1'b1;
    repeat (10) @(negedge i_clock);
    i_rst = 1'b0;
    rc(rtcp_pkg::ADR_RT_MODE, 8'hFF, 8'h00);
    rc(rtcp_pkg::ADR_DOM, 8'hFF, 8'h01);
    `CHK({xs, bb, armed, irq}, 5'h00)
    $display("test reset done");
    // test mode entry, clear, exit with oscillator stopped
    h.wr(rtcp_pkg::ADR_PERIODIC, 8'h80);
    rc(rtcp_pkg::ADR_PERIODIC, 8'h80, 8'h80);
    h.wr(rtcp_pkg::ADR_TEST_CTL, 8'h40);
    rc(rtcp_pkg::ADR_PERIODIC, 8'h40, 8'h00);
    h.wr(rtcp_pkg::ADR_TEST_CTL, 8'h00);
    rc(rtcp_pkg::ADR_TEST_CTL, 8'hFF, 8'h00);
    rc(rtcp_pkg::ADR_PERIODIC, 8'h40, 8'h40);
    h.wr(rtcp_pkg::ADR_PERIODIC, 8'h00);
    rc(rtcp_pkg::ADR_PERIODIC, 8'hC0, 8'h40);
    settle;
    `CHK(bb, 1'b0)
    $display("test init done");
    // every crystal code
    for (k = 0; k < 4; k++) begin
      h.wr(rtcp_pkg::ADR_RT_MODE, {k[1:0], 6'h00});
      rc(rtcp_pkg::ADR_RT_MODE, 8'hC0, {k[1:0], 6'h00});
      `CHK(xs, k[1:0])
    end
    // start refused while the oscillator is stopped
    h.wr(rtcp_pkg::ADR_RT_MODE, 8'h40);
    h.wr(rtcp_pkg::ADR_RT_MODE, 8'h48);
    rc(rtcp_pkg::ADR_RT_MODE, 8'hC8, 8'h40);
    osc = 1'b1;
    for (n = 0; n < 20; n++) begin
      h.wr(rtcp_pkg::ADR_RT_MODE, 8'h48);
      h.rd(rtcp_pkg::ADR_PERIODIC, d, ok);
      if (ok && d[6] === 1'b0)
        break;
    end
    rc(rtcp_pkg::ADR_PERIODIC, 8'h40, 8'h00);
    rc(rtcp_pkg::ADR_RT_MODE, 8'hC8, 8'h48);
    $display("test start done");
    // supply mode selection both ways
    h.wr(rtcp_pkg::ADR_PERIODIC, 8'h00);
    settle;
    `CHK(bb, 1'b1)
    h.wr(rtcp_pkg::ADR_PERIODIC, 8'h40);
    settle;
    `CHK(bb, 1'b0)
    rc(rtcp_pkg::ADR_PERIODIC, 8'h40, 8'h00);
    h.wr(rtcp_pkg::ADR_PERIODIC, 8'h00);
    $display("test supply done");
    // day rollover from 23:59:59.99 with the clock stopped first
    h.wr(rtcp_pkg::ADR_RT_MODE, 8'h40);
    h.wr(rtcp_pkg::ADR_HOURS, 8'h23);
    h.wr(rtcp_pkg::ADR_MINUTES, 8'h59);
    h.wr(rtcp_pkg::ADR_SECONDS, 8'h59);
    h.wr(rtcp_pkg::ADR_HUNDREDTHS, 8'h99);
    h.wr(rtcp_pkg::ADR_RT_MODE, 8'h48);
    repeat (12) @(negedge i_clock);
    rc(rtcp_pkg::ADR_SECONDS, 8'hFF, 8'h00);
    rc(rtcp_pkg::ADR_MINUTES, 8'hFF, 8'h00);
    rc(rtcp_pkg::ADR_HOURS, 8'hFF, 8'h00);
    rc(rtcp_pkg::ADR_DOM, 8'hFF, 8'h02);
    rc(rtcp_pkg::ADR_DOW, 8'hFF, 8'h02);
    rc(rtcp_pkg::ADR_DOY_LO, 8'hFF, 8'h02);
    // 12 hour mode: 11 AM rolls over to 12 PM, no new day
    h.wr(rtcp_pkg::ADR_RT_MODE, 8'h44);
    h.wr(rtcp_pkg::ADR_HOURS, 8'h11);
    h.wr(rtcp_pkg::ADR_MINUTES, 8'h59);
    h.wr(rtcp_pkg::ADR_SECONDS, 8'h59);
    h.wr(rtcp_pkg::ADR_HUNDREDTHS, 8'h99);
    h.wr(rtcp_pkg::ADR_RT_MODE, 8'h4C);
    repeat (12) @(negedge i_clock);
    rc(rtcp_pkg::ADR_HOURS, 8'hFF, 8'h92);
    rc(rtcp_pkg::ADR_DOM, 8'hFF, 8'h02);
    $display("test calendar done");
    // spare bytes and page switch
    h.wr(rtcp_pkg::ADR_ALM_SEC, 8'h5A);
    rc(rtcp_pkg::ADR_ALM_SEC, 8'hFF, 8'h5A);
    h.wr(rtcp_pkg::ADR_SAVE_DOM, 8'hC3);
    rc(rtcp_pkg::ADR_SAVE_DOM, 8'hFF, 8'hC3);
    h.wr(rtcp_pkg::ADR_MAIN_STATUS, 8'h40);
    h.wr(rtcp_pkg::ADR_DOM, 8'hA5);
    rc(rtcp_pkg::ADR_DOM, 8'hFF, 8'hA5);
    h.wr(rtcp_pkg::ADR_MAIN_STATUS, 8'h00);
    rc(rtcp_pkg::ADR_DOM, 8'hFF, 8'h02);
    $display("test pages done");
    // arming, standby hold, then a power failure
    h.wr(rtcp_pkg::ADR_INT_CTL1, 8'h80);
    settle;
    `CHK(armed, 1'b1)
    stby = 1'b1;
    settle;
    `CHK(armed, 1'b0)
    stby = 1'b0;
    h.wr(rtcp_pkg::ADR_RT_MODE, 8'h58);
    h.wr(rtcp_pkg::ADR_INT_CTL1, 8'h80);
    stby = 1'b1;
    settle;
    `CHK(armed, 1'b1)
    stby = 1'b0;
    pf_n = 1'b0;
    settle;
    `CHK(irq, 1'b1)
    h.rd(rtcp_pkg::ADR_DOM, d, ok);
    `CHK(ok, 1'b0)
    pf_n = 1'b1;
    settle;
    rc(rtcp_pkg::ADR_MAIN_STATUS, 8'h02, 8'h02);
    rc(rtcp_pkg::ADR_SAVE_DOM, 8'hFF, 8'h02);
    rc(rtcp_pkg::ADR_SAVE_HOUR, 8'hFF, 8'h92);
    $display("test power fail done");
    finish_test;
  end
endmodule

/* File: rtcp_core.sv */
// real time clock: bus slave, calendar, supply mode and power fail control
`timescale 1ns/100ps
module rtcp_core #(
  parameter int TICK_CYCLES = rtcp_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic       i_clock,
  input  wire logic       i_rst,
  // memory-like processor bus
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [4:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  // oscillator and supply sensing
  input  wire logic       i_osc_running,
  input  wire logic       i_backup_above_main,
  input  wire logic       i_power_fail_input_n,
  // control outputs
  output logic      [1:0] o_crystal_select,
  output logic            o_battery_backed,
  output logic            o_power_fail_armed,
  output logic            o_interrupt
);

  // register state
  logic [7:0] rt_mode_reg, int_ctl0_reg, int_ctl1_reg, test_ctl_reg;
  logic       test_mode_reg, batt_mode_reg, page_reg, wr_n_prev_reg;
  logic       pf_flag_reg, per_flag_reg, alm_flag_reg, lock_reg;
  logic [7:0] hund_reg, sec_reg, min_reg, hour_reg, dom_reg;
  logic [7:0] month_reg, year_reg, doy_lo_reg, doy_hi_reg, dow_reg;
  logic [7:0] ram0_reg [16];
  logic [7:0] ram1_reg [32];
  logic [31:0] tick_cnt_reg;
  logic       tick, wr_stb, rd_act, osc_fail, pf_detect, leap;
  logic       c_sec, c_min, c_hour, c_day, c_month, c_year, hr12;
  logic [7:0] status_rd, rd_val;

  // BCD increment without wrap
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last day of a month, BCD; leap decides February
  function automatic logic [7:0] month_len(input logic [7:0] m,
                                           input logic lp);
    case (m)
      8'h02:                      month_len = lp ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
      default:                    month_len = 8'h31;
    endcase
  endfunction

  // page 0 RAM index from bus address
  function automatic logic [3:0] ram_idx(input logic [4:0] a);
    ram_idx = 4'(a - rtcp_pkg::ADR_RAM_FIRST);
  endfunction

  // bus decode; the bus is ignored entirely while locked out
  assign wr_stb = ~i_cs_n & ~i_wr_n & wr_n_prev_reg & ~lock_reg;
  assign rd_act = ~i_cs_n & ~i_rd_n & ~lock_reg;
  // suppress bit in the test register masks the failure flag
  assign osc_fail = ~i_osc_running
                  & ~test_ctl_reg[rtcp_pkg::BIT_OSC_SUPPRESS];
  assign pf_detect = int_ctl1_reg[rtcp_pkg::BIT_PF_ENABLE]
                   & ~i_power_fail_input_n;
  assign leap = (rt_mode_reg[1:0] == 2'h0);
  assign hr12 = rt_mode_reg[rtcp_pkg::BIT_HOUR_12];

  // write strobe taken on the falling edge of the write line
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      wr_n_prev_reg <= 1'b1;
    end else begin
      wr_n_prev_reg <= i_wr_n;
    end
  end

  // hundredths tick divider, runs only when started and oscillating
  always_ff @(posedge i_clock) begin
    if (i_rst || !rt_mode_reg[rtcp_pkg::BIT_CLOCK_START]) begin
      tick_cnt_reg <= '0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
    end else if (i_osc_running) begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  // carry chain through the calendar
  always_comb begin
    c_sec   = tick && hund_reg == 8'h99;
    c_min   = c_sec && sec_reg == 8'h59;
    c_hour  = c_min && min_reg == 8'h59;
    c_day   = c_hour && (hr12 ? hour_reg == 8'h91 : hour_reg == 8'h23);
    c_month = c_day && dom_reg == month_len(month_reg, leap);
    c_year  = c_month && month_reg == 8'h12;
  end

  // timekeeping counters; a processor write wins over a count
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      hund_reg   <= rtcp_pkg::RST_ZERO;
      sec_reg    <= rtcp_pkg::RST_ZERO;
      min_reg    <= rtcp_pkg::RST_ZERO;
      hour_reg   <= rtcp_pkg::RST_ZERO;
      dom_reg    <= rtcp_pkg::RST_ONE;
      month_reg  <= rtcp_pkg::RST_ONE;
      year_reg   <= rtcp_pkg::RST_ZERO;
      doy_lo_reg <= rtcp_pkg::RST_DOY;
      doy_hi_reg <= rtcp_pkg::RST_ZERO;
      dow_reg    <= rtcp_pkg::RST_ONE;
    end else if (wr_stb && !page_reg) begin
      unique case (i_addr)
        rtcp_pkg::ADR_HUNDREDTHS: hund_reg   <= i_data;
        rtcp_pkg::ADR_SECONDS:    sec_reg    <= i_data;
        rtcp_pkg::ADR_MINUTES:    min_reg    <= i_data;
        rtcp_pkg::ADR_HOURS:      hour_reg   <= i_data;
        rtcp_pkg::ADR_DOM:        dom_reg    <= i_data;
        rtcp_pkg::ADR_MONTH:      month_reg  <= i_data;
        rtcp_pkg::ADR_YEAR:       year_reg   <= i_data;
        rtcp_pkg::ADR_DOY_LO:     doy_lo_reg <= i_data;
        rtcp_pkg::ADR_DOY_HI:     doy_hi_reg <= i_data;
        rtcp_pkg::ADR_DOW:        dow_reg    <= i_data;
        default: ;
      endcase
    end else if (tick) begin
      hund_reg <= c_sec ? 8'h00 : bcd_inc(hund_reg);
      if (c_sec) sec_reg <= c_min ? 8'h00 : bcd_inc(sec_reg);
      if (c_min) min_reg <= c_hour ? 8'h00 : bcd_inc(min_reg);
      // 12 hour: D7 is PM, 11 to 12 flips it, 12 rolls to 01
      if (c_hour && hr12) begin
        if (hour_reg[4:0] == 5'h12) begin
          hour_reg <= {hour_reg[7], 7'h01};
        end else if (hour_reg[4:0] == 5'h11) begin
          hour_reg <= {~hour_reg[7], 7'h12};
        end else begin
          hour_reg <= {hour_reg[7], 2'h0,
                       5'(bcd_inc({3'h0, hour_reg[4:0]}))};
        end
      end else if (c_hour) begin
        hour_reg <= c_day ? 8'h00 : bcd_inc(hour_reg);
      end
      // day counters kept separately
      if (c_day) begin
        dom_reg <= c_month ? 8'h01 : bcd_inc(dom_reg);
        dow_reg <= (dow_reg == 8'h07) ? 8'h01 : bcd_inc(dow_reg);
        if (c_year) begin
          doy_lo_reg <= 8'h01;
          doy_hi_reg <= 8'h00;
        end else if (doy_lo_reg == 8'h99) begin
          doy_lo_reg <= 8'h00;
          doy_hi_reg <= bcd_inc(doy_hi_reg);
        end else begin
          doy_lo_reg <= bcd_inc(doy_lo_reg);
        end
      end
      if (c_month) month_reg <= c_year ? 8'h01 : bcd_inc(month_reg);
      if (c_year) year_reg <= (year_reg == 8'h99) ? 8'h00 : bcd_inc(year_reg);
    end
  end

  // leap counter in mode D1:D0 counts down on new year, else software
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      rt_mode_reg <= rtcp_pkg::RST_ZERO;
    end else if (wr_stb && !page_reg && i_addr == rtcp_pkg::ADR_RT_MODE) begin
      rt_mode_reg <= i_data;
      // a stopped oscillator refuses the start bit
      if (!i_osc_running) begin
        rt_mode_reg[rtcp_pkg::BIT_CLOCK_START] <= 1'b0;
      end
    end else if (c_year) begin
      rt_mode_reg[1:0] <= rt_mode_reg[1:0] - 2'h1;
    end
  end

  // periodic flag register: test mode and supply mode
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      test_mode_reg <= 1'b0;
      batt_mode_reg <= 1'b0;
    end else if (wr_stb && !page_reg && i_addr == rtcp_pkg::ADR_PERIODIC) begin
      test_mode_reg <= i_data[rtcp_pkg::BIT_TEST_MODE];
      // only the supply mode moves; oscillator status is live
      if (i_data[rtcp_pkg::BIT_SUPPLY_MODE]) begin
        batt_mode_reg <= 1'b0;
      end else if (!osc_fail) begin
        batt_mode_reg <= 1'b1;
      end
    end
  end

  // test register writable only in test mode, zero clears it
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      test_ctl_reg <= rtcp_pkg::RST_ZERO;
    end else if (wr_stb && !page_reg && test_mode_reg
                 && i_addr == rtcp_pkg::ADR_TEST_CTL) begin
      test_ctl_reg <= i_data;
    end
  end

  // interrupt controls; power fail enable held through standby
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      int_ctl0_reg <= rtcp_pkg::RST_ZERO;
      int_ctl1_reg <= rtcp_pkg::RST_ZERO;
    end else begin
      if (wr_stb && !page_reg && i_addr == rtcp_pkg::ADR_INT_CTL0) begin
        int_ctl0_reg <= i_data;
      end
      if (wr_stb && !page_reg && i_addr == rtcp_pkg::ADR_INT_CTL1) begin
        int_ctl1_reg <= i_data;
      end else if (i_backup_above_main
                   && !rt_mode_reg[rtcp_pkg::BIT_PF_HOLD]) begin
        // without the hold bit standby drops detection to save power
        int_ctl1_reg[rtcp_pkg::BIT_PF_ENABLE] <= 1'b0;
      end
    end
  end

  // page select and sticky flags; a new event beats a clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      page_reg     <= 1'b0;
      pf_flag_reg  <= 1'b0;
      per_flag_reg <= 1'b0;
      alm_flag_reg <= 1'b0;
    end else begin
      if (wr_stb && i_addr == rtcp_pkg::ADR_MAIN_STATUS) begin
        page_reg <= i_data[rtcp_pkg::BIT_PAGE_SEL];
        if (i_data[rtcp_pkg::BIT_PF_FLAG])     pf_flag_reg  <= 1'b0;
        if (i_data[rtcp_pkg::BIT_PERIOD_FLAG]) per_flag_reg <= 1'b0;
        if (i_data[rtcp_pkg::BIT_ALARM_FLAG])  alm_flag_reg <= 1'b0;
      end
      if (pf_detect) pf_flag_reg <= 1'b1;
      if (c_sec) per_flag_reg <= 1'b1;
      if (c_sec && sec_reg == 8'h59 - 8'h00
          && ram0_reg[ram_idx(rtcp_pkg::ADR_ALM_MIN)] == min_reg
          && ram0_reg[ram_idx(rtcp_pkg::ADR_ALM_HOUR)] == hour_reg) begin
        alm_flag_reg <= 1'b1;
      end
    end
  end

  // lockout follows detection; released when the pin recovers
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      lock_reg <= 1'b0;
    end else begin
      lock_reg <= pf_detect;
    end
  end

  // alarm/save/general RAM on page 0, plain RAM on page 1
  always_ff @(posedge i_clock) begin
    if (wr_stb && !page_reg && i_addr >= rtcp_pkg::ADR_RAM_FIRST
        && i_addr != rtcp_pkg::ADR_TEST_CTL) begin
      ram0_reg[ram_idx(i_addr)] <= i_data;
    end
    if (wr_stb && page_reg && i_addr != rtcp_pkg::ADR_MAIN_STATUS) begin
      ram1_reg[i_addr] <= i_data;
    end
    // time logged once, on the first cycle of a failure
    if (pf_detect && !lock_reg) begin
      ram0_reg[ram_idx(rtcp_pkg::ADR_SAVE_SEC)]   <= sec_reg;
      ram0_reg[ram_idx(rtcp_pkg::ADR_SAVE_MIN)]   <= min_reg;
      ram0_reg[ram_idx(rtcp_pkg::ADR_SAVE_HOUR)]  <= hour_reg;
      ram0_reg[ram_idx(rtcp_pkg::ADR_SAVE_DOM)]   <= dom_reg;
      ram0_reg[ram_idx(rtcp_pkg::ADR_SAVE_MONTH)] <= month_reg;
    end
  end

  // read mux
  always_comb begin
    status_rd = 8'h00;
    status_rd[rtcp_pkg::BIT_PAGE_SEL]    = page_reg;
    status_rd[rtcp_pkg::BIT_PF_FLAG]     = pf_flag_reg;
    status_rd[rtcp_pkg::BIT_PERIOD_FLAG] = per_flag_reg;
    status_rd[rtcp_pkg::BIT_ALARM_FLAG]  = alm_flag_reg;
    status_rd[rtcp_pkg::BIT_INT_PENDING] = o_interrupt;
    rd_val = 8'h00;
    if (i_addr == rtcp_pkg::ADR_MAIN_STATUS) begin
      rd_val = status_rd;
    end else if (page_reg) begin
      rd_val = ram1_reg[i_addr];
    end else if (i_addr >= rtcp_pkg::ADR_RAM_FIRST
                 && i_addr != rtcp_pkg::ADR_TEST_CTL) begin
      rd_val = ram0_reg[ram_idx(i_addr)];
    end else begin
      unique case (i_addr)
        rtcp_pkg::ADR_RT_MODE:    rd_val = rt_mode_reg;
        rtcp_pkg::ADR_PERIODIC:   rd_val = {test_mode_reg, osc_fail,
                                            6'h00};
        rtcp_pkg::ADR_INT_CTL0:   rd_val = int_ctl0_reg;
        rtcp_pkg::ADR_INT_CTL1:   rd_val = int_ctl1_reg;
        rtcp_pkg::ADR_HUNDREDTHS: rd_val = hund_reg;
        rtcp_pkg::ADR_SECONDS:    rd_val = sec_reg;
        rtcp_pkg::ADR_MINUTES:    rd_val = min_reg;
        rtcp_pkg::ADR_HOURS:      rd_val = hour_reg;
        rtcp_pkg::ADR_DOM:        rd_val = dom_reg;
        rtcp_pkg::ADR_MONTH:      rd_val = month_reg;
        rtcp_pkg::ADR_YEAR:       rd_val = year_reg;
        rtcp_pkg::ADR_DOY_LO:     rd_val = doy_lo_reg;
        rtcp_pkg::ADR_DOY_HI:     rd_val = doy_hi_reg;
        rtcp_pkg::ADR_DOW:        rd_val = dow_reg;
        rtcp_pkg::ADR_TEST_CTL:   rd_val = test_ctl_reg;
        default:                  rd_val = 8'h00;
      endcase
    end
  end

  // registered outputs; data lags the strobe by one clock
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_data             <= 8'h00;
      o_data_oe          <= 1'b0;
      o_crystal_select   <= rtcp_pkg::XTAL_32K768;
      o_battery_backed   <= 1'b0;
      o_power_fail_armed <= 1'b0;
      o_interrupt        <= 1'b0;
    end else begin
      o_data             <= rd_act ? rd_val : 8'h00;
      o_data_oe          <= rd_act;
      o_crystal_select   <= rt_mode_reg[7:6];
      o_battery_backed   <= batt_mode_reg;
      o_power_fail_armed <= int_ctl1_reg[rtcp_pkg::BIT_PF_ENABLE];
      o_interrupt        <= pf_flag_reg
        | (per_flag_reg & int_ctl0_reg[rtcp_pkg::BIT_SECOND_EN])
        | (alm_flag_reg & int_ctl1_reg[rtcp_pkg::BIT_ALARM_EN]);
    end
  end

  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  sequence s_wr_p0(logic [4:0] a);
    wr_stb && !page_reg && i_addr == a;
  endsequence

  property p_test_enter;
    s_wr_p0(rtcp_pkg::ADR_PERIODIC) ##0 i_data[7] |=> test_mode_reg;
  endproperty
  a_test_enter: assert property (p_test_enter)
    else $error("no test mode");
  property p_test_clear;
    s_wr_p0(rtcp_pkg::ADR_TEST_CTL) ##0 (test_mode_reg && i_data == 8'h00)
      |=> test_ctl_reg == 8'h00 && !test_ctl_reg[6];
  endproperty
  a_test_clear: assert property (p_test_clear)
    else $error("test kept");
  property p_test_leave;
    s_wr_p0(rtcp_pkg::ADR_PERIODIC) ##0 !i_data[7] |=> !test_mode_reg;
  endproperty
  a_test_leave: assert property (p_test_leave)
    else $error("still test");
  property p_xtal;
    s_wr_p0(rtcp_pkg::ADR_RT_MODE)
      |-> ##2 o_crystal_select == $past(i_data[7:6], 2);
  endproperty
  a_xtal: assert property (p_xtal)
    else $error("crystal select wrong");
  property p_start_refused;
    s_wr_p0(rtcp_pkg::ADR_RT_MODE) ##0 !i_osc_running |=> !rt_mode_reg[3];
  endproperty
  a_start_refused: assert property (p_start_refused)
    else $error("start taken");
  property p_osc_read;
    rd_act && !page_reg && i_addr == rtcp_pkg::ADR_PERIODIC
      |=> o_data_oe && o_data[6] == $past(osc_fail);
  endproperty
  a_osc_read: assert property (p_osc_read)
    else $error("osc fail read");
  property p_bb_refused;
    s_wr_p0(rtcp_pkg::ADR_PERIODIC) ##0 (!i_data[6] && osc_fail)
      |=> batt_mode_reg == $past(batt_mode_reg);
  endproperty
  a_bb_refused: assert property (p_bb_refused)
    else $error("backed on fail");
  property p_pf_hold;
    i_backup_above_main && rt_mode_reg[4] && int_ctl1_reg[7]
      && !(wr_stb && !page_reg && i_addr == rtcp_pkg::ADR_INT_CTL1)
      |=> int_ctl1_reg[7];
  endproperty
  a_pf_hold: assert property (p_pf_hold)
    else $error("pf enable lost");
  property p_lockout;
    pf_detect |=> ##1 !o_data_oe ##0 o_interrupt;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("bus not locked");
  property p_save;
    pf_detect && !lock_reg |=>
      ram0_reg[ram_idx(rtcp_pkg::ADR_SAVE_SEC)] == $past(sec_reg);
  endproperty
  a_save: assert property (p_save)
    else $error("time not saved");

endmodule

/* File: rtcp_host.sv */
// host processor model driving the memory-like register bus
`timescale 1ns/100ps
module rtcp_host (
  // clock
  input  wire logic       i_clock,
  // read answer from the device
  input  wire logic [7:0] i_data,
  input  wire logic       i_data_oe,
  // bus strobes, address and write data
  output logic            o_cs_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [4:0] o_addr,
  output logic      [7:0] o_data
);
  // bus idle at time zero
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_addr = 5'h00;
    o_data = 8'h00;
  end

  // one write per falling strobe; idle data inverted so none is stale
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge i_clock);
    o_cs_n = 1'b0;
    o_addr = a;
    o_data = d;
    o_wr_n = 1'b0;
    @(negedge i_clock);
    o_wr_n = 1'b1;
    o_cs_n = 1'b1;
    o_data = ~d;
  endtask

  // read held until the device drives data, bounded for lockout
  task automatic rd(input logic [4:0] a, output logic [7:0] d,
                    output logic ok);
    int n;
    @(negedge i_clock);
    o_cs_n = 1'b0;
    o_addr = a;
    o_rd_n = 1'b0;
    ok = 1'b0;
    d = 8'h00;
    for (n = 0; n < 3 && !ok; n++) begin
      @(negedge i_clock);
      ok = (i_data_oe === 1'b1);
      d = i_data;
    end
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
  endtask
endmodule

/* File: rtcp_pkg.sv */
// constants, register map and field layout of the real time clock block
//
// Operation
// - writing periodic flag D7 one enters test mode
// - zero to test register clears all test conditions
// - writing periodic flag D7 zero leaves test mode
// - mode register D7:D6 select crystal frequency
// - clock start accepted only while oscillator runs
// - periodic flag D6 reads oscillator failure status
// - periodic flag D6 zero selects battery backed
// - battery backed entered only without oscillator failure
// - control one D7 enables power fail detection
// - mode D4 holds power fail enable in standby
// - address space is two pages of 32 bytes
// - BCD time, hundredths to year, leap, 12/24h
// - separate day of week, month, year counters
// - power fail raises interrupt and locks bus
// - power fail copies time into save RAM
// - periodic, alarm and power fail interrupt sources
// - unused alarm and save bytes are plain RAM
package rtcp_pkg;
  // register offsets within a page
  localparam logic [4:0] ADR_MAIN_STATUS = 5'h00;
  localparam logic [4:0] ADR_RT_MODE     = 5'h01;
  localparam logic [4:0] ADR_PERIODIC    = 5'h02;
  localparam logic [4:0] ADR_INT_CTL0    = 5'h03;
  localparam logic [4:0] ADR_INT_CTL1    = 5'h04;
  localparam logic [4:0] ADR_HUNDREDTHS  = 5'h05;
  localparam logic [4:0] ADR_SECONDS     = 5'h06;
  localparam logic [4:0] ADR_MINUTES     = 5'h07;
  localparam logic [4:0] ADR_HOURS       = 5'h08;
  localparam logic [4:0] ADR_DOM         = 5'h09;
  localparam logic [4:0] ADR_MONTH       = 5'h0A;
  localparam logic [4:0] ADR_YEAR        = 5'h0B;
  localparam logic [4:0] ADR_DOY_LO      = 5'h0C;
  localparam logic [4:0] ADR_DOY_HI      = 5'h0D;
  localparam logic [4:0] ADR_DOW         = 5'h0E;
  localparam logic [4:0] ADR_RAM_FIRST   = 5'h0F;
  localparam logic [4:0] ADR_ALM_SEC     = 5'h0F;
  localparam logic [4:0] ADR_ALM_MIN     = 5'h10;
  localparam logic [4:0] ADR_ALM_HOUR    = 5'h11;
  localparam logic [4:0] ADR_SAVE_SEC    = 5'h12;
  localparam logic [4:0] ADR_SAVE_MIN    = 5'h13;
  localparam logic [4:0] ADR_SAVE_HOUR   = 5'h14;
  localparam logic [4:0] ADR_SAVE_DOM    = 5'h15;
  localparam logic [4:0] ADR_SAVE_MONTH  = 5'h16;
  localparam logic [4:0] ADR_TEST_CTL    = 5'h1F;
  // bit positions
  localparam int BIT_PAGE_SEL     = 6;
  localparam int BIT_INT_PENDING  = 0;
  localparam int BIT_PF_FLAG      = 1;
  localparam int BIT_PERIOD_FLAG  = 2;
  localparam int BIT_ALARM_FLAG   = 3;
  localparam int BIT_TEST_MODE    = 7;
  localparam int BIT_OSC_FAIL     = 6;
  localparam int BIT_SUPPLY_MODE  = 6;
  localparam int BIT_CLOCK_START  = 3;
  localparam int BIT_PF_HOLD      = 4;
  localparam int BIT_HOUR_12      = 2;
  localparam int BIT_PF_ENABLE    = 7;
  localparam int BIT_ALARM_EN     = 3;
  localparam int BIT_SECOND_EN    = 1;
  localparam int BIT_OSC_SUPPRESS = 6;
  localparam int BIT_PM           = 7;
  // crystal select codes in mode register D7:D6
  localparam logic [1:0] XTAL_32K768 = 2'h0;
  localparam logic [1:0] XTAL_4M1943 = 2'h1;
  localparam logic [1:0] XTAL_4M9152 = 2'h2;
  localparam logic [1:0] XTAL_32K000 = 2'h3;
  // reset values
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] RST_ONE   = 8'h01;
  localparam logic [7:0] RST_DOY   = 8'h01;
  // timing: hundredths tick from the 50 MHz system clock
  localparam int TICK_PERIOD_NS = 10000000;
  localparam int CLK_PERIOD_NS  = 20;
  localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
endpackage
